// >>> psl_ctrl.v
// The implementer's own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
// How it works
// - LED mode bit picks blink/duplex display style.
// - Link LED on with link, 10 Hz activity.
// - Activity LED blinks 20 Hz on half-duplex.
// - Activity LED steady full-duplex, blinks on collision.
// - Speed LED on at 100, off 10; LED follows control bit 13 gated by link, off in fiber at 100 with it clear.
// - Control bit 15 resets registers, latches and crossover search, self-clears.
// - Both resets reload defaults from sampled straps.
// - Status bit six reports suppression; control enables.
// - Frames without preamble accepted; idle between.
// - Local fault sets advertised bit 13, renegotiates on copper.
// - Advertised fault bit clears after good negotiation.
// - Partner fault bit sets status remote fault.
// - Transmit isolate ignores MAC, tri-states, no pulses.
// - Swap pairs before negotiation when crossed.
// - Fiber bypasses scrambler, MLT3, equalizer, descrambler.
// - Signal detect picks fiber; both low twisted.
// - Fiber disables negotiation; strap or software only.
// - Far-end fault on in fiber, sends indication.
// - Partner fault forces link fail, sets status.
// - Fiber sends idle whenever not transmitting.
`include "psl_defs.vh"

module psl_ctrl #(
  parameter BLINK_SLOW_HALF = `PSL_BLINK_SLOW_HALF_US * `PSL_CLK_MHZ,
  parameter BLINK_FAST_HALF = `PSL_BLINK_FAST_HALF_US * `PSL_CLK_MHZ,
  parameter MDIX_WINDOW     = `PSL_MDIX_WINDOW_US * `PSL_CLK_MHZ
) (
  input  wire        i_clk,
  input  wire        i_srst,
  input  wire [6:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  input  wire [3:0]  i_avs_byteenable,
  output reg  [31:0] o_avs_readdata,
  output reg         o_avs_waitrequest,
  input  wire        i_strap_speed100,
  input  wire        i_strap_full_duplex,
  input  wire        i_strap_an_en,
  input  wire        i_strap_fiber,
  input  wire        i_link_up,
  input  wire        i_activity,
  input  wire        i_collision,
  input  wire        i_tx_en,
  input  wire        i_link_pulse_seen,
  input  wire        i_local_fault,
  input  wire        i_an_success,
  input  wire        i_lp_word_valid,
  input  wire [15:0] i_lp_word,
  input  wire        i_signal_detect_pos,
  input  wire        i_signal_detect_neg,
  input  wire        i_rx_fef_seen,
  output reg         o_led_link,
  output reg         o_led_speed,
  output reg         o_led_act,
  output reg         o_led_oe,
  output reg         o_soft_reset,
  output reg         o_speed100,
  output reg         o_full_duplex,
  output reg         o_an_enable,
  output reg         o_an_restart,
  output reg  [15:0] o_adv_word,
  output reg         o_preamble_suppress,
  output reg         o_mac_isolate,
  output reg         o_link_pulse_en,
  output reg         o_mdix_swap,
  output reg         o_fiber_mode,
  output reg  [3:0]  o_bypass,
  output reg         o_tx_fef,
  output reg         o_link_fail_force,
  output reg         o_tx_idle
);

  localparam ST_SEARCH = 1'h0;
  localparam ST_LOCKED = 1'h1;

  // ****************************************************************
  // Helpers.
  // ****************************************************************
  function [15:0] merge;
    input [15:0] old;
    input [31:0] wdata;
    input [3:0]  be;
    begin
      merge[7:0]  = be[0] ? wdata[7:0]  : old[7:0];
      merge[15:8] = be[1] ? wdata[15:8] : old[15:8];
    end
  endfunction

  function [22:0] count_down;
    input [22:0] cnt;
    input [22:0] reload;
    begin
      count_down = (cnt == 23'h00_0000) ? reload : cnt - 23'h00_0001;
    end
  endfunction

  // ****************************************************************
  // State.
  // ****************************************************************
  reg         strap_speed100;
  reg         strap_full_duplex;
  reg         strap_an_en;
  reg         strap_fiber;
  reg  [15:0] ctl;
  reg  [15:0] adv;
  reg  [15:0] ftx;
  reg  [15:0] pre;
  reg  [15:0] led_cfg;
  reg         rf_status;
  reg         an_done;
  reg         sw_rst;
  reg  [22:0] slow_cnt;
  reg  [22:0] fast_cnt;
  reg         slow_sq;
  reg         fast_sq;
  reg         mdix_state;
  reg  [22:0] mdix_cnt;

  wire        reg_rst = i_srst | sw_rst;
  wire        req = (i_avs_read | i_avs_write) & o_avs_waitrequest;
  wire        wr = req & i_avs_write;
  wire        rd = req & i_avs_read;
  wire [4:0]  idx = i_avs_address[6:2];
  wire        sd_valid = i_signal_detect_pos ^ i_signal_detect_neg;
  wire        sig_ok = i_signal_detect_pos & ~i_signal_detect_neg;
  // Any valid signal-detect pair selects fiber, but only the pos-high pair means
  // the optical link itself is good enough to monitor for a far-end fault.
  wire        fiber = strap_fiber | ftx[`PSL_FTX_FIBER_FORCE] | sd_valid;
  wire        fef_on = fiber & ftx[`PSL_FTX_FEF_EN];
  wire        isolate = ftx[`PSL_FTX_TX_ISOLATE];
  wire        fef_hit = fef_on & sig_ok & i_rx_fef_seen;
  wire        lp_fault = i_lp_word_valid & i_lp_word[`PSL_ADV_REMOTE_FAULT];
  wire        stat_rd = rd & (idx == `PSL_IDX_BASIC_STAT);
  wire [15:0] status;

  assign status = {9'h000, 1'h1, an_done, rf_status, 1'h0, i_link_up, 2'h0};

  // ****************************************************************
  // Strap capture while the hardware reset is held.
  // ****************************************************************
  always @(posedge i_clk) begin
    if (i_srst) begin
      strap_speed100    <= i_strap_speed100;
      strap_full_duplex <= i_strap_full_duplex;
      strap_an_en       <= i_strap_an_en;
      strap_fiber       <= i_strap_fiber;
    end
  end

  // ****************************************************************
  // Avalon-MM slave: one answer cycle with waitrequest low.
  // ****************************************************************
  // Only the hardware reset touches the slave, so the write that asks for a soft
  // reset still receives its answer cycle.
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_avs_waitrequest <= 1'h1;
      o_avs_readdata    <= 32'h0000_0000;
    end else if (req) begin
      o_avs_waitrequest <= 1'h0;
      o_avs_readdata    <= 32'h0000_0000;
      if (i_avs_read) begin
        case (idx)
          `PSL_IDX_BASIC_CTRL:    o_avs_readdata[15:0] <= ctl;
          `PSL_IDX_BASIC_STAT:    o_avs_readdata[15:0] <= status;
          `PSL_IDX_ADV:           o_avs_readdata[15:0] <= adv;
          `PSL_IDX_FAST_TX_CTRL:  o_avs_readdata[15:0] <= ftx;
          `PSL_IDX_PREAMBLE_CTRL: o_avs_readdata[15:0] <= pre;
          `PSL_IDX_LED_CONFIG:    o_avs_readdata[15:0] <= led_cfg;
          default:                o_avs_readdata[15:0] <= 16'h0000;
        endcase
      end
    end else begin
      o_avs_waitrequest <= 1'h1;
    end
  end

  // ****************************************************************
  // Register file; soft reset reloads every default next cycle.
  // ****************************************************************
  always @(posedge i_clk) begin
    if (reg_rst) begin
      ctl <= {2'h0, (i_srst ? i_strap_speed100 : strap_speed100),
              (i_srst ? i_strap_an_en : strap_an_en), 3'h0,
              (i_srst ? i_strap_full_duplex : strap_full_duplex), 8'h00};
      adv     <= `PSL_ADV_RESET;
      ftx     <= `PSL_FTX_RESET;
      pre     <= `PSL_PRE_RESET;
      led_cfg <= `PSL_LED_RESET;
      sw_rst  <= 1'h0;
    end else begin
      sw_rst <= wr & (idx == `PSL_IDX_BASIC_CTRL) &
                i_avs_byteenable[1] & i_avs_writedata[`PSL_CTL_SOFT_RESET];
      if (wr && idx == `PSL_IDX_BASIC_CTRL)
        ctl <= merge(ctl, i_avs_writedata, i_avs_byteenable);
      if (wr && idx == `PSL_IDX_FAST_TX_CTRL)
        ftx <= merge(ftx, i_avs_writedata, i_avs_byteenable);
      if (wr && idx == `PSL_IDX_PREAMBLE_CTRL)
        pre <= merge(pre, i_avs_writedata, i_avs_byteenable);
      if (wr && idx == `PSL_IDX_LED_CONFIG)
        led_cfg <= merge(led_cfg, i_avs_writedata, i_avs_byteenable);
      if (wr && idx == `PSL_IDX_ADV)
        adv <= merge(adv, i_avs_writedata, i_avs_byteenable);
      // The fault bit stays set until a good negotiation; a new fault wins.
      if (i_local_fault)
        adv[`PSL_ADV_REMOTE_FAULT] <= 1'h1;
      else if (i_an_success)
        adv[`PSL_ADV_REMOTE_FAULT] <= 1'h0;
    end
  end

  // ****************************************************************
  // Status latches: remote fault clears on read, a new event wins.
  // ****************************************************************
  always @(posedge i_clk) begin
    if (reg_rst) begin
      rf_status <= 1'h0;
      an_done   <= 1'h0;
    end else begin
      if (lp_fault || fef_hit)
        rf_status <= 1'h1;
      else if (stat_rd)
        rf_status <= 1'h0;
      // Negotiation only runs on copper, and its done flag drops with the link.
      if (i_an_success && !fiber)
        an_done <= 1'h1;
      else if (!i_link_up)
        an_done <= 1'h0;
    end
  end

  // ****************************************************************
  // Blink generators.
  // ****************************************************************
  // The blink counters run through a soft reset so the LEDs keep their rhythm.
  always @(posedge i_clk) begin
    if (i_srst) begin
      slow_cnt <= 23'h00_0000;
      fast_cnt <= 23'h00_0000;
      slow_sq  <= 1'h0;
      fast_sq  <= 1'h0;
    end else begin
      slow_cnt <= count_down(slow_cnt, BLINK_SLOW_HALF[22:0] - 23'h00_0001);
      fast_cnt <= count_down(fast_cnt, BLINK_FAST_HALF[22:0] - 23'h00_0001);
      if (slow_cnt == 23'h00_0000)
        slow_sq <= ~slow_sq;
      if (fast_cnt == 23'h00_0000)
        fast_sq <= ~fast_sq;
    end
  end

  // ****************************************************************
  // Crossover search ahead of negotiation.
  // ****************************************************************
  // With no partner heard the pairs swap once per window; any pulse, a link or
  // fiber freezes the current choice until the partner is lost again.
  always @(posedge i_clk) begin
    if (reg_rst) begin
      mdix_state  <= ST_SEARCH;
      mdix_cnt    <= 23'h00_0000;
      o_mdix_swap <= 1'h0;
    end else begin
      case (mdix_state)
        ST_SEARCH: begin
          if (fiber || i_link_pulse_seen || i_link_up) begin
            mdix_state <= ST_LOCKED;
          end else if (mdix_cnt == MDIX_WINDOW[22:0] - 23'h00_0001) begin
            mdix_cnt    <= 23'h00_0000;
            o_mdix_swap <= ~o_mdix_swap;
          end else begin
            mdix_cnt <= mdix_cnt + 23'h00_0001;
          end
        end
        ST_LOCKED: begin
          mdix_cnt <= 23'h00_0000;
          if (!i_link_up && !i_link_pulse_seen && !fiber)
            mdix_state <= ST_SEARCH;
        end
        default: mdix_state <= ST_SEARCH;
      endcase
    end
  end

  // ****************************************************************
  // Registered outputs.
  // ****************************************************************
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_led_link          <= 1'h0;
      o_led_speed         <= 1'h0;
      o_led_act           <= 1'h0;
      o_led_oe            <= 1'h0;
      o_soft_reset        <= 1'h0;
      o_speed100          <= 1'h0;
      o_full_duplex       <= 1'h0;
      o_an_enable         <= 1'h0;
      o_an_restart        <= 1'h0;
      o_adv_word          <= 16'h0000;
      o_preamble_suppress <= 1'h0;
      o_mac_isolate       <= 1'h0;
      o_link_pulse_en     <= 1'h0;
      o_fiber_mode        <= 1'h0;
      o_bypass            <= 4'h0;
      o_tx_fef            <= 1'h0;
      o_link_fail_force   <= 1'h0;
      o_tx_idle           <= 1'h0;
    end else begin
      // Strap pins double as LED pins, so drive only after reset.
      o_led_oe    <= ~sw_rst;
      o_led_speed <= i_link_up & ctl[`PSL_CTL_SPEED100];
      if (led_cfg[`PSL_LED_MODE]) begin
        o_led_link <= i_link_up & ~(i_activity & slow_sq);
        o_led_act  <= i_collision ? fast_sq : ctl[`PSL_CTL_FULL_DUPLEX];
      end else begin
        o_led_link <= i_link_up;
        o_led_act  <= i_activity & ~ctl[`PSL_CTL_FULL_DUPLEX] & fast_sq;
      end
      o_soft_reset        <= sw_rst;
      o_speed100          <= ctl[`PSL_CTL_SPEED100] | fiber;
      o_full_duplex       <= ctl[`PSL_CTL_FULL_DUPLEX];
      o_an_enable         <= ctl[`PSL_CTL_AN_EN] & ~fiber;
      // A local fault renegotiates only on copper; fiber has no negotiation.
      o_an_restart        <= i_local_fault & ~fiber;
      o_adv_word          <= adv;
      o_preamble_suppress <= pre[`PSL_PRE_SUPP_EN];
      o_mac_isolate       <= isolate;
      o_link_pulse_en     <= ~isolate & ~fiber;
      o_fiber_mode        <= fiber;
      o_bypass            <= {4{fiber}};
      // Isolation silences the fault indication along with the link pulses.
      o_tx_fef            <= fef_on & ~sig_ok & ~isolate;
      o_link_fail_force   <= fef_hit;
      o_tx_idle           <= fiber & ~(i_tx_en & ~isolate);
    end
  end

endmodule

// >>> psl_ctrl_sva.sv
`timescale 1ns/1ps
// ****************************************************************
// Port checker for the control block.
// ****************************************************************
module psl_ctrl_sva (
  input wire logic        i_clk,
  input wire logic        i_srst,
  input wire logic [6:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0]  i_avs_byteenable,
  input wire logic        o_avs_waitrequest,
  input wire logic        i_link_up,
  input wire logic        i_local_fault,
  input wire logic        i_an_success,
  input wire logic        i_tx_en,
  input wire logic        i_signal_detect_pos,
  input wire logic        i_signal_detect_neg,
  input wire logic        o_led_link,
  input wire logic        o_led_speed,
  input wire logic        o_soft_reset,
  input wire logic        o_speed100,
  input wire logic        o_an_restart,
  input wire logic [15:0] o_adv_word,
  input wire logic        o_mac_isolate,
  input wire logic        o_link_pulse_en,
  input wire logic        o_fiber_mode,
  input wire logic [3:0]  o_bypass,
  input wire logic        o_tx_fef,
  input wire logic        o_tx_idle
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence bus_taken;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence bus_answer;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence
  sequence ctl_rst_taken;
    bus_taken ##0 (i_avs_write && i_avs_address[6:2] == 5'h00 && i_avs_writedata[15] && i_avs_byteenable[1]);
  endsequence
  bus_answer_a: assert property (bus_taken |=> bus_answer)
    else $error("bus answer not one cycle");
  soft_reset_a: assert property (ctl_rst_taken |-> ##[1:4] o_soft_reset)
    else $error("soft reset pulse missing");
  link_led_off_a: assert property ($past(!i_link_up) |-> !o_led_link)
    else $error("link LED lit without link");
  speed_led_a: assert property (o_led_speed |-> $past(i_link_up) && o_speed100)
    else $error("speed LED without link at 100");
  fiber_detect_a: assert property ($past(i_signal_detect_pos ^ i_signal_detect_neg) |-> o_fiber_mode)
    else $error("fiber mode not selected");
  bypass_set_a: assert property (o_bypass == {4{o_fiber_mode}})
    else $error("bypass does not follow fiber mode");
  fiber_no_an_a: assert property (o_fiber_mode && $past(i_local_fault) |-> !o_an_restart)
    else $error("negotiation restart in fiber mode");
  adv_fault_a: assert property (i_local_fault |-> ##[1:2] o_adv_word[13])
    else $error("advertised fault bit not set");
  adv_clear_a: assert property (i_an_success && !i_local_fault |-> ##[1:2] !o_adv_word[13])
    else $error("advertised fault bit not cleared");
  tx_isolate_a: assert property (o_mac_isolate |-> !o_link_pulse_en && !o_tx_fef)
    else $error("isolation leaks pulses");
  fiber_idle_a: assert property ($past(o_fiber_mode && !i_tx_en) && o_fiber_mode |-> o_tx_idle)
    else $error("no idle in fiber mode");
endmodule
bind psl_ctrl psl_ctrl_sva chk_u (.i_clk, .i_srst, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
  .i_avs_byteenable, .o_avs_waitrequest, .i_link_up, .i_local_fault, .i_an_success, .i_tx_en, .i_signal_detect_pos,
  .i_signal_detect_neg, .o_led_link, .o_led_speed, .o_soft_reset, .o_speed100, .o_an_restart, .o_adv_word,
  .o_mac_isolate, .o_link_pulse_en, .o_fiber_mode, .o_bypass, .o_tx_fef, .o_tx_idle);

// >>> psl_ctrl_test.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
// ****************************************************************
// Self-checking bench for the control block.
// ****************************************************************
module psl_ctrl_test;
  logic        i_clk, i_srst, i_avs_read, i_avs_write, i_link_up, i_activity, i_collision, i_tx_en;
  logic        i_local_fault, i_an_success, i_strap_speed100, i_strap_full_duplex, i_strap_an_en, i_strap_fiber;
  logic [6:0]  i_avs_address;
  logic [31:0] i_avs_writedata;
  logic [3:0]  i_avs_byteenable;
  wire  [31:0] o_avs_readdata;
  wire  [15:0] o_adv_word, lp_word;
  wire  [3:0]  o_bypass;
  wire         o_avs_waitrequest, o_led_link, o_led_speed, o_led_act, o_led_oe, o_soft_reset, o_speed100;
  wire         o_full_duplex, o_an_enable, o_an_restart, o_preamble_suppress, o_mac_isolate, o_link_pulse_en;
  wire         o_mdix_swap, o_fiber_mode, o_tx_fef, o_link_fail_force, o_tx_idle, lp_valid, sdp, sdn, fef, pls;
  int          n_errors = 0;
  int          cmp_count = 0;
  psl_ctrl #(.BLINK_SLOW_HALF(8), .BLINK_FAST_HALF(4), .MDIX_WINDOW(16)) dut_u (.i_clk, .i_srst, .i_avs_address,
    .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest,
    .i_strap_speed100, .i_strap_full_duplex, .i_strap_an_en, .i_strap_fiber, .i_link_up, .i_activity, .i_collision,
    .i_tx_en, .i_link_pulse_seen(pls), .i_local_fault, .i_an_success, .i_lp_word_valid(lp_valid), .i_lp_word(lp_word),
    .i_signal_detect_pos(sdp), .i_signal_detect_neg(sdn), .i_rx_fef_seen(fef), .o_led_link, .o_led_speed, .o_led_act,
    .o_led_oe, .o_soft_reset, .o_speed100, .o_full_duplex, .o_an_enable, .o_an_restart, .o_adv_word,
    .o_preamble_suppress, .o_mac_isolate, .o_link_pulse_en, .o_mdix_swap, .o_fiber_mode, .o_bypass, .o_tx_fef,
    .o_link_fail_force, .o_tx_idle);
  psl_partner partner_u (.i_clk, .o_word_valid(lp_valid), .o_word(lp_word), .o_sd_pos(sdp), .o_sd_neg(sdn),
    .o_fef_seen(fef), .o_pulse_seen(pls));
  task complete_run;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task bus(input logic is_wr, input logic [6:0] a, input logic [15:0] d, output logic [15:0] q);
    int k;
    @(posedge i_clk);
    i_avs_address   <= a;
    i_avs_writedata <= {16'h0000, d};
    i_avs_read      <= ~is_wr;
    i_avs_write     <= is_wr;
    for (k = 0; k < 50; k++) begin
      @(posedge i_clk);
      if (o_avs_waitrequest === 1'b0) break;
    end
    if (k == 50) begin
      n_errors++;
      complete_run;
    end
    q = o_avs_readdata[15:0];
    i_avs_read  <= 1'b0;
    i_avs_write <= 1'b0;
  endtask
  task wr16(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, a, d, q);
  endtask
  task rd_chk(input string nm, input logic [6:0] a, input logic [15:0] m, input logic [15:0] e);
    logic [15:0] q;
    bus(1'b0, a, 16'h0000, q);
    `CHK(nm, e, q & m)
  endtask
  // Counts toggles of the two blinking LEDs and the pair swap over a fixed span.
  task watch(output int nl, output int na, output int nm);
    logic l, a, m;
    {nl, na, nm} = '0;
    {l, a, m} = {o_led_link, o_led_act, o_mdix_swap};
    repeat (48) begin
      @(posedge i_clk);
      nl += int'(o_led_link !== l);
      na += int'(o_led_act !== a);
      nm += int'(o_mdix_swap !== m);
      {l, a, m} = {o_led_link, o_led_act, o_mdix_swap};
    end
  endtask
  // Pulses one event input and counts negotiation restarts that follow.
  task pulse(input logic succ, output int ns);
    ns = 0;
    @(posedge i_clk);
    i_local_fault <= ~succ;
    i_an_success  <= succ;
    @(posedge i_clk);
    {i_local_fault, i_an_success} <= 2'b00;
    repeat (4) begin
      @(posedge i_clk);
      ns += int'(o_an_restart === 1'b1);
    end
  endtask
  task t_defaults;
    rd_chk("ctl", 7'h00, 16'hFFFF, 16'h3000);
    rd_chk("stat_pre", 7'h04, 16'h0040, 16'h0040);
    rd_chk("adv", 7'h10, 16'hFFFF, 16'h01E1);
    rd_chk("ftx", 7'h4C, 16'hFFFF, 16'h0010);
    rd_chk("unmapped", 7'h7C, 16'hFFFF, 16'h0000);
  endtask
  task t_soft_reset;
    int k;
    wr16(7'h50, 16'h0002);
    tick(2);
    `CHK("pre_on", 1'b1, o_preamble_suppress)
    wr16(7'h6C, 16'h0200);
    {i_strap_speed100, i_strap_an_en} <= 2'b00;
    wr16(7'h00, 16'h8000);
    for (k = 0; k < 10 && o_soft_reset !== 1'b1; k++) @(posedge i_clk);
    `CHK("soft_pulse", 1'b1, o_soft_reset)
    `CHK("oe_off", 1'b0, o_led_oe)
    rd_chk("ctl_clr", 7'h00, 16'hFFFF, 16'h3000);
    rd_chk("pre_rst", 7'h50, 16'hFFFF, 16'h0000);
    rd_chk("led_rst", 7'h6C, 16'hFFFF, 16'h0000);
    `CHK("pre_off", 1'b0, o_preamble_suppress)
    `CHK("oe_on", 1'b1, o_led_oe)
  endtask
  task t_leds;
    int nl, na, nm;
    {i_link_up, i_activity} <= 2'b11;
    tick(4);
    watch(nl, na, nm);
    `CHK("m0_link", 1'b1, o_led_link === 1'b1 && nl == 0)
    `CHK("m0_act", 1'b1, na >= 10)
    `CHK("speed_on", 1'b1, o_led_speed)
    wr16(7'h6C, 16'h0200);
    tick(4);
    watch(nl, na, nm);
    `CHK("m1_link", 1'b1, nl >= 5)
    `CHK("m1_act", 1'b1, o_led_act === 1'b0 && na == 0)
    i_collision <= 1'b1;
    tick(4);
    watch(nl, na, nm);
    `CHK("col_act", 1'b1, na >= 10)
    i_collision <= 1'b0;
    wr16(7'h00, 16'h1100);
    tick(4);
    watch(nl, na, nm);
    `CHK("fd_act", 1'b1, o_led_act === 1'b1 && na == 0)
    `CHK("speed_off", 1'b0, o_led_speed)
    `CHK("fd_out", 1'b1, o_full_duplex)
    `CHK("an_on", 1'b1, o_an_enable)
    {i_link_up, i_activity} <= 2'b00;
    tick(3);
    `CHK("link_off", 1'b0, o_led_link)
  endtask
  task t_fault;
    int ns;
    partner_u.send_word(16'h2000);
    tick(2);
    rd_chk("stat_rf", 7'h04, 16'h0010, 16'h0010);
    rd_chk("stat_rf_clr", 7'h04, 16'h0010, 16'h0000);
    pulse(1'b0, ns);
    `CHK("restart", 1'b1, ns == 1)
    rd_chk("adv_rf", 7'h10, 16'h2000, 16'h2000);
    pulse(1'b1, ns);
    rd_chk("adv_rf_clr", 7'h10, 16'h2000, 16'h0000);
    wr16(7'h4C, 16'h0030);
    tick(2);
    `CHK("iso", 1'b1, o_mac_isolate === 1'b1 && o_link_pulse_en === 1'b0)
    wr16(7'h4C, 16'h0010);
    tick(2);
    `CHK("iso_off", 1'b1, o_link_pulse_en)
  endtask
  task t_fiber;
    int nl, na, nm;
    watch(nl, na, nm);
    `CHK("mdix", 1'b1, nm >= 2)
    partner_u.set_line(1'b1, 1'b0, 1'b0);
    tick(3);
    `CHK("fx_on", 1'b1, o_fiber_mode)
    `CHK("fx_byp", 4'hF, o_bypass)
    `CHK("fx_an_off", 1'b0, o_an_enable)
    `CHK("fx_spd", 1'b1, o_speed100)
    `CHK("fx_idle", 1'b1, o_tx_idle === 1'b1 && o_tx_fef === 1'b0)
    pulse(1'b0, nm);
    `CHK("fx_no_an", 1'b1, nm == 0)
    i_tx_en <= 1'b1;
    partner_u.set_line(1'b1, 1'b0, 1'b1);
    tick(3);
    `CHK("fx_busy", 1'b0, o_tx_idle)
    `CHK("lnk_fail", 1'b1, o_link_fail_force)
    rd_chk("fx_rf", 7'h04, 16'h0010, 16'h0010);
    i_tx_en <= 1'b0;
    partner_u.set_line(1'b0, 1'b1, 1'b0);
    tick(3);
    `CHK("fx_fef", 1'b1, o_tx_fef)
    partner_u.set_line(1'b0, 1'b0, 1'b0);
    tick(3);
    `CHK("tp", 1'b1, o_fiber_mode === 1'b0 && o_bypass === 4'h0)
  endtask
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    n_errors++;
    complete_run;
  end
  initial begin
    {i_srst, i_avs_read, i_avs_write, i_link_up, i_activity, i_collision, i_tx_en} = 7'h01 << 6;
    {i_local_fault, i_an_success, i_strap_full_duplex, i_strap_fiber} = 4'h0;
    {i_strap_speed100, i_strap_an_en} = 2'b11;
    i_avs_address = 7'h00;
    i_avs_writedata = 32'h0000_0000;
    i_avs_byteenable = 4'h3;
    repeat (3) @(posedge i_clk);
    i_srst <= 1'b0;
    t_defaults;
    t_soft_reset;
    t_leds;
    t_fault;
    t_fiber;
    complete_run;
  end
endmodule

// >>> psl_defs.vh
`ifndef PSL_DEFS_VH
`define PSL_DEFS_VH

// ****************************************************************
// Register indices; byte address is four times the index.
// ****************************************************************
`define PSL_IDX_BASIC_CTRL    5'h00
`define PSL_IDX_BASIC_STAT    5'h01
`define PSL_IDX_ADV           5'h04
`define PSL_IDX_FAST_TX_CTRL  5'h13
`define PSL_IDX_PREAMBLE_CTRL 5'h14
`define PSL_IDX_LED_CONFIG    5'h1B

// ****************************************************************
// Field positions.
// ****************************************************************
`define PSL_CTL_SOFT_RESET    15
`define PSL_CTL_SPEED100      13
`define PSL_CTL_AN_EN         12
`define PSL_CTL_FULL_DUPLEX   8
`define PSL_STA_PRE_SUPP      6
`define PSL_STA_AN_DONE       5
`define PSL_STA_REMOTE_FAULT  4
`define PSL_STA_LINK          2
`define PSL_ADV_REMOTE_FAULT  13
`define PSL_FTX_TX_ISOLATE    5
`define PSL_FTX_FEF_EN        4
`define PSL_FTX_FIBER_FORCE   0
`define PSL_PRE_SUPP_EN       1
`define PSL_LED_MODE          9

// ****************************************************************
// Reset values.
// ****************************************************************
`define PSL_ADV_RESET         16'h01E1
`define PSL_FTX_RESET         16'h0010
`define PSL_PRE_RESET         16'h0000
`define PSL_LED_RESET         16'h0000

// ****************************************************************
// Coding stage bypass vector positions.
// ****************************************************************
`define PSL_BYP_SCRAMBLE      0
`define PSL_BYP_MLT3          1
`define PSL_BYP_EQUALIZER     2
`define PSL_BYP_DESCRAMBLE    3

// ****************************************************************
// Timing.
// ****************************************************************
`define PSL_CLK_MHZ           100
`define PSL_BLINK_SLOW_HALF_US 50000
`define PSL_BLINK_FAST_HALF_US 25000
`define PSL_MDIX_WINDOW_US    1000

`endif

// >>> psl_partner.sv
`timescale 1ns/1ps
// ****************************************************************
// Remote link partner seen from the control block.
// ****************************************************************
module psl_partner (
  input  wire logic  i_clk,
  output logic       o_word_valid,
  output logic [15:0] o_word,
  output logic       o_sd_pos,
  output logic       o_sd_neg,
  output logic       o_fef_seen,
  output logic       o_pulse_seen
);
  initial begin
    {o_word_valid, o_word, o_sd_pos, o_sd_neg, o_fef_seen, o_pulse_seen} = '0;
  end
  // The word is only meaningful with its strobe; afterwards it shows the inverse.
  task send_word(input logic [15:0] w);
    @(posedge i_clk);
    o_word_valid <= 1'b1;
    o_word       <= w;
    @(posedge i_clk);
    o_word_valid <= 1'b0;
    o_word       <= ~w;
  endtask
  task set_line(input logic p, input logic n, input logic f);
    @(posedge i_clk);
    o_sd_pos   <= p;
    o_sd_neg   <= n;
    o_fef_seen <= f;
  endtask
endmodule
